// >>> rtl/vip_defines.vh
// Constants for the vectored interrupt prioritizer
`ifndef VIP_DEFINES_VH
`define VIP_DEFINES_VH
// Source count and grouping
`define VIP_NUM_SRC 24
`define VIP_NUM_PIN_SRC 12
`define VIP_NUM_PERIPH_SRC 12
// Fixed vector table addresses, 16 bits, two-byte slots
`define VIP_VEC_RESET 16'h0002
`define VIP_VEC_WDT 16'h0004
`define VIP_VEC_TRAP 16'h0006
`define VIP_VEC_FIRST_SRC 16'h0008
`define VIP_VEC_PIN_FIRST 16'h0018
`define VIP_VEC_PIN_LAST 16'h0026
`define VIP_VEC_LATE_FIRST 16'h0028
`define VIP_VEC_LATE_LAST 16'h002E
`define VIP_VEC_DUAL_FIRST 16'h0030
`define VIP_VEC_DUAL_LAST 16'h0036
`define VIP_VEC_STEP 16'h0002
// Priority level encodings; zero means source disabled
`define VIP_LVL_OFF 2'h0
`define VIP_LVL_LOW 2'h1
`define VIP_LVL_MID 2'h2
`define VIP_LVL_HIGH 2'h3
// Source index layout, index 0 is highest ranked (timer 2)
`define VIP_IDX_PIN_BASE 8
`define VIP_IDX_LATE_BASE 16
`define VIP_IDX_DUAL_BASE 20
// Reset values
`define VIP_RST_PEND 24'h00_0000
`define VIP_RST_EDGE 8'h00
`endif

// >>> rtl/vip_edge_detect.v
// Pin synchroniser and edge detector producing one-cycle request pulses
`timescale 1ns/10ps
module vip_edge_detect #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pin_in,
  input wire [WIDTH-1:0] edge_en_rise,
  input wire [WIDTH-1:0] edge_en_fall,
  output reg [WIDTH-1:0] edge_pulse
);
  reg [WIDTH-1:0] sync_a; // First stage, read only by sync_b
  reg [WIDTH-1:0] sync_b; // Second stage, safe to read
  reg [WIDTH-1:0] last; // Previous synchronised level
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] fall;

  assign rise = sync_b & ~last;
  assign fall = ~sync_b & last;

  // Two-flop synchroniser, history and pulse registers
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_a <= {WIDTH{1'b0}};
      sync_b <= {WIDTH{1'b0}};
      last <= {WIDTH{1'b0}};
      edge_pulse <= {WIDTH{1'b0}};
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      last <= sync_b;
      // Pulse lasts exactly one clock
      edge_pulse <= (rise & edge_en_rise) | (fall & edge_en_fall);
    end
  end
endmodule

// >>> rtl/vip_vectored_interrupt_prioritizer.v
// Vectored interrupt prioritizer: pending bits, levels, ranking and vector output
// Overview of operation
// - Twenty-four source vectors plus reset, trap
// - Twelve pin sources and twelve peripheral sources
// - Eight pins trigger on selected single edge
// - Four pins dual-edge, lowest four vectors
// - Each source has three-level programmable priority
// - Watchdog may interrupt through vector 0004
// - Reset owns top vector 0002, not interrupt
// - Illegal trap vector 0006 below watchdog
// - Eight shared pin vectors, pin7 down
// - Then timer3, serial1 rx, tx, DMA
// - Vector MSB even address, LSB odd
// - Polling ignores enables; pending stays readable
// - Higher level wins; fixed order breaks ties
// - Pulse sets pending; ack or write clears
// - Global enable cleared by reset, ack, write
`timescale 1ns/10ps
`include "vip_defines.vh"
module vip_vectored_interrupt_prioritizer #(
  parameter NUM_SRC = `VIP_NUM_SRC,
  parameter NUM_EDGE_PINS = 8,
  parameter NUM_DUAL_PINS = 4
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] periph_req,
  input wire [3:0] late_req,
  input wire [7:0] port_first_pin,
  input wire [7:0] port_fourth_pin,
  input wire [7:0] port_select_fourth,
  input wire [7:0] edge_sel_fall,
  input wire [3:0] port_third_pin,
  input wire wdt_irq_enable,
  input wire wdt_event,
  input wire trap_event,
  input wire [2*NUM_SRC-1:0] src_level,
  input wire sw_pend_wr,
  input wire [NUM_SRC-1:0] sw_pend_data,
  input wire sw_gie_wr,
  input wire sw_gie_data,
  input wire core_ack,
  output reg [NUM_SRC-1:0] pending,
  output reg global_interrupt_enable,
  output reg wdt_pending,
  output wire irq_request,
  output reg [15:0] irq_vector,
  output reg [4:0] irq_src_index,
  output reg [15:0] reset_vector
);
  // Pin sources: shared pins chosen per bit, then edge detected
  wire [7:0] shared_pin; // Selected pin of first or fourth port
  wire [7:0] shared_pulse; // Single-edge request pulses
  wire [3:0] dual_pulse; // Dual-edge request pulses
  wire [NUM_SRC-1:0] raw_req; // All source pulses in rank order
  wire [NUM_SRC-1:0] gated; // Pending and enabled sources
  reg [NUM_SRC-1:0] next_pending;
  reg [4:0] win_idx; // Winning source index
  reg win_valid; // Some enabled source pending
  reg [1:0] win_lvl; // Level of the current winner
  reg [1:0] lvl_i; // Loop scratch level
  reg next_gie;
  // Look-ahead winner so the vector register matches the request
  reg next_wdt_view; // Watchdog will be pending after this edge
  reg [4:0] next_win_idx; // Winner among next pending bits
  reg next_win_valid; // Some enabled source will be pending
  reg [1:0] next_win_lvl; // Level of the look-ahead winner
  reg [1:0] nlvl; // Loop scratch level, look-ahead
  integer i; // Loop index, current arbiter only
  integer j; // Loop index, look-ahead arbiter only

  // Returns the level field of one source
  function [1:0] level_of;
    input [2*`VIP_NUM_SRC-1:0] lv;
    input integer idx;
    begin
      level_of = lv[2*idx +: 2];
    end
  endfunction

  // Returns table address for a source index, two bytes per slot
  function [15:0] vector_of;
    input [4:0] idx;
    begin
      vector_of = `VIP_VEC_FIRST_SRC + {10'h000, idx, 1'b0};
    end
  endfunction

  // Pin mux, one of the two ports per shared vector
  assign shared_pin = (port_fourth_pin & port_select_fourth) | (port_first_pin & ~port_select_fourth);

  // Eight single-edge pins; rising unless falling selected
  vip_edge_detect #(
    .WIDTH(NUM_EDGE_PINS)
  ) u_edge_shared (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(shared_pin),
    .edge_en_rise(~edge_sel_fall),
    .edge_en_fall(edge_sel_fall),
    .edge_pulse(shared_pulse)
  );

  // Four dual-edge pins, both edges always enabled
  vip_edge_detect #(
    .WIDTH(NUM_DUAL_PINS)
  ) u_edge_dual (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(port_third_pin),
    .edge_en_rise(4'hF),
    .edge_en_fall(4'hF),
    .edge_pulse(dual_pulse)
  );

  // Rank order: index 0 highest. Pin vectors run pin7 down to pin0,
  // so bit order is reversed into the index space.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_rank
      assign raw_req[g] = periph_req[7-g];
      assign raw_req[`VIP_IDX_PIN_BASE+g] = shared_pulse[7-g];
    end
    for (g = 0; g < 4; g = g + 1)
    begin : g_rank_late
      assign raw_req[`VIP_IDX_LATE_BASE+g] = late_req[3-g];
      assign raw_req[`VIP_IDX_DUAL_BASE+g] = dual_pulse[3-g];
    end
  endgenerate

  // Level zero removes a source from vectored service only
  generate
    for (g = 0; g < NUM_SRC; g = g + 1)
    begin : g_gate
      assign gated[g] = pending[g] & (src_level[2*g +: 2] != `VIP_LVL_OFF);
    end
  endgenerate

  // Arbiter: highest level first, lowest index breaks ties
  always @*
  begin
    win_idx = 5'h00;
    win_valid = 1'b0;
    win_lvl = `VIP_LVL_OFF;
    lvl_i = `VIP_LVL_OFF;
    for (i = 0; i < NUM_SRC; i = i + 1)
    begin
      lvl_i = level_of(src_level, i);
      // Strictly greater keeps the earlier, higher-ranked source
      if (gated[i] && (!win_valid || lvl_i > win_lvl))
      begin
        win_idx = i[4:0];
        win_valid = 1'b1;
        win_lvl = lvl_i;
      end
    end
  end

  // Request to core; watchdog outranks every source regardless of level
  assign irq_request = global_interrupt_enable & (wdt_pending | win_valid);

  // Pending next state; set beats clear in the same cycle
  always @*
  begin
    next_pending = pending;
    // Software write replaces value; also creates software requests
    if (sw_pend_wr)
    begin
      next_pending = sw_pend_data;
    end
    // Acknowledge clears only the serviced source
    if (core_ack && irq_request && !wdt_pending)
    begin
      next_pending[win_idx] = 1'b0;
    end
    // New pulses always land, so no event is lost
    next_pending = next_pending | raw_req;
  end

  // Global enable next state
  always @*
  begin
    next_gie = global_interrupt_enable;
    if (sw_gie_wr)
    begin
      next_gie = sw_gie_data;
    end
    // Ack disables so the handler starts uninterrupted
    if (core_ack && irq_request)
    begin
      next_gie = 1'b0;
    end
  end

  // State registers
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pending <= `VIP_RST_PEND;
      global_interrupt_enable <= 1'b0;
      wdt_pending <= 1'b0;
    end
    else
    begin
      pending <= next_pending;
      global_interrupt_enable <= next_gie;
      // Watchdog event only counts when configured as interrupt
      if (wdt_event && wdt_irq_enable)
      begin
        wdt_pending <= 1'b1;
      end
      else if (core_ack && irq_request && wdt_pending)
      begin
        wdt_pending <= 1'b0;
      end
    end
  end

  // Registered vector and index for the current winner
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_vector <= `VIP_VEC_RESET;
      irq_src_index <= 5'h00;
      reset_vector <= `VIP_VEC_RESET;
    end
    else
    begin
      reset_vector <= `VIP_VEC_RESET;
      // Trap is not an interrupt; it ignores enable and levels
      if (trap_event)
      begin
        irq_vector <= `VIP_VEC_TRAP;
        irq_src_index <= 5'h00;
      end
      else if (next_wdt_view)
      begin
        irq_vector <= `VIP_VEC_WDT;
        irq_src_index <= 5'h00;
      end
      else
      begin
        irq_vector <= vector_of(next_win_idx);
        irq_src_index <= next_win_idx;
      end
    end
  end

  // Look-ahead arbiter; same ranking as the current one, on next pending
  always @*
  begin
    next_wdt_view = (wdt_event & wdt_irq_enable) | (wdt_pending & ~(core_ack & irq_request));
    next_win_idx = 5'h00;
    next_win_valid = 1'b0;
    next_win_lvl = `VIP_LVL_OFF;
    nlvl = `VIP_LVL_OFF;
    for (j = 0; j < NUM_SRC; j = j + 1)
    begin
      nlvl = level_of(src_level, j);
      if (next_pending[j] && nlvl != `VIP_LVL_OFF && (!next_win_valid || nlvl > next_win_lvl))
      begin
        next_win_idx = j[4:0];
        next_win_valid = 1'b1;
        next_win_lvl = nlvl;
      end
    end
  end
endmodule

// >>> verification/vip_core_model.sv
// Core model that acknowledges presented requests
`timescale 1ns/10ps
module vip_core_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire irq_request,
  input wire accept_en,
  input wire [3:0] ack_wait,
  output reg core_ack
);
  reg [3:0] wait_cnt; // Cycles waited so far
  initial core_ack = 1'b0;
  // One-cycle ack after a settable wait, so slow cores are covered too
  always @(posedge ref_clk)
  begin
    if (sys_rst || !irq_request || !accept_en || core_ack)
    begin
      wait_cnt <= 4'h0;
      core_ack <= 1'b0;
    end
    else if (wait_cnt == ack_wait)
      core_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// >>> verification/vip_prio_assertions.sv
// Port checker for the interrupt prioritizer
`timescale 1ns/10ps
module vip_prio_assertions #(
  parameter NUM_SRC = 24
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] periph_req,
  input wire [3:0] late_req,
  input wire trap_event,
  input wire [2*NUM_SRC-1:0] src_level,
  input wire sw_pend_wr,
  input wire [NUM_SRC-1:0] sw_pend_data,
  input wire sw_gie_wr,
  input wire sw_gie_data,
  input wire core_ack,
  input wire [NUM_SRC-1:0] pending,
  input wire global_interrupt_enable,
  input wire wdt_pending,
  input wire irq_request,
  input wire [15:0] irq_vector,
  input wire [4:0] irq_src_index,
  input wire [15:0] reset_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_entry_fixed: assert property (reset_vector == 16'h0002) else $error("reset entry moved");
  a_pulse_sets_pend: assert property (periph_req[7] |=> pending[0]) else $error("request lost");
  a_ack_drops_gie: assert property (core_ack && irq_request && !sw_gie_wr |=> !global_interrupt_enable)
    else $error("enable kept after ack");
  a_gie_write_lands: assert property (sw_gie_wr && !core_ack |=> global_interrupt_enable == $past(sw_gie_data))
    else $error("enable write lost");
  a_request_needs_gie: assert property (irq_request |-> global_interrupt_enable) else $error("ungated request");
  a_vector_even: assert property (irq_vector[0] == 1'b0) else $error("odd vector");
  a_vector_slot: assert property (irq_request && !wdt_pending && !$past(wdt_pending) && $stable(pending)
    && $stable(src_level) && !$past(trap_event) |-> irq_vector == 16'h0008 + {10'h000, irq_src_index, 1'b0})
    else $error("vector slot wrong");
  a_watchdog_wins: assert property (wdt_pending && $past(wdt_pending) && !$past(trap_event)
    && global_interrupt_enable |-> irq_vector == 16'h0004) else $error("watchdog outranked");
  a_pend_write: assert property (sw_pend_wr && !core_ack && periph_req == 8'h00 && late_req == 4'h0
    |=> pending == $past(sw_pend_data)) else $error("pending write lost");
  // Main scenarios reached
  c_ack: cover property (core_ack && irq_request);
  c_wdt: cover property (wdt_pending && irq_request);
  c_write: cover property (sw_pend_wr);
endmodule
bind vip_vectored_interrupt_prioritizer vip_prio_assertions #(.NUM_SRC(NUM_SRC)) u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .periph_req(periph_req), .late_req(late_req), .trap_event(trap_event), .src_level(src_level),
  .sw_pend_wr(sw_pend_wr), .sw_pend_data(sw_pend_data), .sw_gie_wr(sw_gie_wr), .sw_gie_data(sw_gie_data),
  .core_ack(core_ack), .pending(pending), .global_interrupt_enable(global_interrupt_enable),
  .wdt_pending(wdt_pending), .irq_request(irq_request), .irq_vector(irq_vector), .irq_src_index(irq_src_index),
  .reset_vector(reset_vector));

// >>> verification/vip_vectored_interrupt_prioritizer_tb.sv
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/10ps
module vip_vectored_interrupt_prioritizer_tb;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] periph_req = 8'h00;
  reg [3:0] late_req = 4'h0;
  reg [7:0] pin_a = 8'h00; // First port pins
  reg [7:0] pin_d = 8'h00; // Fourth port pins
  reg [7:0] sel_d = 8'h00;
  reg [7:0] fall = 8'h00;
  reg [3:0] pin_c = 4'h0; // Dual-edge pins
  reg wdt_en = 1'b0;
  reg wdt_event = 1'b0;
  reg trap_event = 1'b0;
  reg [47:0] lvl = 48'h0000_0000_0000;
  reg pw_wr = 1'b0;
  reg [23:0] pw_d = 24'h00_0000;
  reg gw = 1'b0;
  reg gd = 1'b0;
  reg accept_en = 1'b0; // Core takes requests
  reg [3:0] ack_wait = 4'h0;
  wire core_ack, gie, wdt_pending, irq_request;
  wire [23:0] pending;
  wire [15:0] irq_vector, reset_vector;
  wire [4:0] irq_src_index;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer i;
  initial forever #2 ref_clk = ~ref_clk;
  vip_vectored_interrupt_prioritizer u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .periph_req(periph_req),
    .late_req(late_req), .port_first_pin(pin_a), .port_fourth_pin(pin_d), .port_select_fourth(sel_d),
    .edge_sel_fall(fall), .port_third_pin(pin_c), .wdt_irq_enable(wdt_en), .wdt_event(wdt_event),
    .trap_event(trap_event), .src_level(lvl), .sw_pend_wr(pw_wr), .sw_pend_data(pw_d), .sw_gie_wr(gw),
    .sw_gie_data(gd), .core_ack(core_ack), .pending(pending), .global_interrupt_enable(gie),
    .wdt_pending(wdt_pending), .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_src_index(irq_src_index), .reset_vector(reset_vector));
  vip_core_model u_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .irq_request(irq_request),
    .accept_en(accept_en), .ack_wait(ack_wait), .core_ack(core_ack));
  task close_out;
  begin
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [23:0] seen, input [23:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One-cycle write strobes, held over one rising edge
  task set_gie(input v);
  begin
    gd = v;
    gw = 1'b1;
    @(negedge ref_clk);
    gw = 1'b0;
  end
  endtask
  task set_pend(input [23:0] d);
  begin
    pw_d = d;
    pw_wr = 1'b1;
    @(negedge ref_clk);
    pw_wr = 1'b0;
  end
  endtask
  // Bounded wait on one pending bit
  task wt(input integer b, input v);
    integer k;
  begin
    k = 0;
    while (pending[b] !== v && k < 20)
    begin
      @(negedge ref_clk);
      k = k + 1;
    end
    if (pending[b] !== v)
    begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  endtask
  // Every non-pin source in turn: slot, request, ack
  task t_order;
    integer x;
  begin
    lvl = {24{2'h2}};
    for (i = 0; i < 12; i = i + 1)
    begin
      x = (i < 8) ? i : i + 8;
      set_gie(1'b1);
      if (i < 8)
        periph_req[7-i] = 1'b1;
      else
        late_req[11-i] = 1'b1;
      @(negedge ref_clk);
      periph_req = 8'h00;
      late_req = 4'h0;
      chk(irq_vector, 16'h0008 + 2 * x);
      chk(irq_src_index, x);
      chk(irq_request, 1'b1);
      ack_wait = i;
      accept_en = 1'b1;
      wt(x, 1'b0);
      accept_en = 1'b0;
      chk(gie, 1'b0);
    end
  end
  endtask
  // Levels beat table order; level zero leaves polling only
  task t_prio;
  begin
    set_pend(24'hFF_FFFF);
    lvl = {2'h3, {23{2'h1}}};
    set_gie(1'b1);
    repeat (2) @(negedge ref_clk);
    chk(irq_vector, 16'h0036);
    lvl = {24{2'h2}};
    repeat (2) @(negedge ref_clk);
    chk(irq_vector, 16'h0008);
    lvl = 48'h0000_0000_0000;
    repeat (2) @(negedge ref_clk);
    chk(irq_request, 1'b0);
    chk(pending, 24'hFF_FFFF);
    set_pend(24'h00_0000);
    set_gie(1'b0);
  end
  endtask
  // Selectable edges, shared pins, dual-edge pins
  task t_pins;
  begin
    pin_a[3] = 1'b1;
    wt(12, 1'b1);
    set_pend(24'h00_0000);
    pin_a[3] = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(pending, 24'h00_0000);
    fall[3] = 1'b1;
    pin_a[3] = 1'b1;
    repeat (6) @(negedge ref_clk);
    pin_a[3] = 1'b0;
    wt(12, 1'b1);
    set_pend(24'h00_0000);
    sel_d[2] = 1'b1;
    pin_d[2] = 1'b1;
    wt(13, 1'b1);
    set_pend(24'h00_0000);
    pin_c[1] = 1'b1;
    wt(22, 1'b1);
    set_pend(24'h00_0000);
    pin_c[1] = 1'b0;
    wt(22, 1'b1);
    set_pend(24'h00_0000);
  end
  endtask
  // Trap steers its cycle; watchdog outranks sources
  task t_wdt;
  begin
    lvl = {24{2'h1}};
    set_pend(24'h00_0001);
    set_gie(1'b1);
    trap_event = 1'b1;
    @(negedge ref_clk);
    trap_event = 0;
    chk(irq_vector, 16'h0006);
    wdt_en = 1'b1;
    wdt_event = 1'b1;
    @(negedge ref_clk);
    wdt_event = 1'b0;
    @(negedge ref_clk);
    chk(irq_vector, 16'h0004);
  end
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    chk(irq_vector, 16'h0002);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk(pending, 24'h00_0000);
    chk(gie, 1'b0);
    chk(reset_vector, 16'h0002);
    t_order;
    t_prio;
    t_pins;
    t_wdt;
    close_out;
  end
endmodule
